/* File: inc/ps2_pkg.sv */
/*
  Constants and carrier types for one port channel controller.
  Assumes a 20 MHz system clock; the line clock comes from the peripheral.
*/
package ps2_pkg;
  localparam int CLK_HZ = 20_000_000;
  localparam int CLK_PERIOD_NS = 1_000_000_000 / CLK_HZ;
  localparam logic [1:0] ADDR_CTRL = 2'h0;
  localparam logic [1:0] ADDR_STATUS = 2'h1;
  localparam logic [1:0] ADDR_TX = 2'h2;
  localparam logic [1:0] ADDR_RX = 2'h3;
  localparam int CTRL_ENABLE_POS = 0;
  localparam int CTRL_TXSEL_POS = 1;
  localparam int STAT_TXIDLE_POS = 0;
  localparam int STAT_RXRDY_POS = 1;
  localparam int STAT_PERR_POS = 2;
  localparam int STAT_EV_TXIDLE_POS = 4;
  localparam int STAT_EV_RXRDY_POS = 5;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam int START_DATA_NS_MIN = 45;
  localparam int START_DATA_NS_MAX = 90;
  localparam int CLK_FLOAT_NS_MIN = 90;
  localparam int CLK_FLOAT_NS_MAX = 130;
  localparam int END_TXSEL_NS_MIN = 3500;
  localparam int END_TXSEL_NS_MAX = 7100;
  localparam int START_DATA_CYC = (START_DATA_NS_MIN + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CLK_FLOAT_CYC = (CLK_FLOAT_NS_MIN + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int END_TXSEL_CYC = (END_TXSEL_NS_MIN + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int FRAME_BITS = 11;

  typedef struct packed {
    logic clk_oe;
    logic data_oe;
  } line_drive_t;

  typedef struct packed {
    logic [1:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } bus_req_t;
endpackage

/* File: rtl/ps2_sync.sv */
/*
  Two-flop synchroniser with edge detection on the synchronised level.
  Assumes the input is asynchronous to clk.
*/
`timescale 1ns/10ps
module ps2_sync (
  // Clock
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  // Level
  input wire logic async_in,
  output logic level,
  output logic fall,
  output logic rise
);
  logic meta_reg, meta_next;
  logic sync_reg, sync_next;
  logic last_reg, last_next;

  always_comb begin
    meta_next = async_in;
    sync_next = meta_reg;
    last_next = sync_reg;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      meta_reg <= 1'b1;
      sync_reg <= 1'b1;
      last_reg <= 1'b1;
    end else if (ce) begin
      meta_reg <= meta_next;
      sync_reg <= sync_next;
      last_reg <= last_next;
    end
  end

  assign level = sync_reg;
  assign fall = last_reg & ~sync_reg;
  assign rise = ~last_reg & sync_reg;
endmodule

/* File: rtl/ps2_channel_controller.sv */
/*
  One channel of a two-wire open-drain keyboard/mouse port controller.
  Assumes the peripheral makes the line clock and the bench resolves the
  open-drain wires from the enables (enable high pulls the wire low).
*/
// What this block does, and what it expects of the peripheral (RQ6 to RQ8)
// (RQ1) Enabled in receive mode, release clock and data lines within 1000 ns.
// (RQ2) Setting transmit select pulls the clock line low to inhibit the peripheral.
// (RQ3) Once the clock line is released for sending, clear transmit-idle within 1.7 us.
// (RQ4) Transmit register write drives start bit low 45 to 90 ns later.
// (RQ5) Transmit register write releases clock line 90 to 130 ns later.
// (RQ6) Peripheral answers start bit by pulling clock low in 0.002 to 25.003 ms.
// (RQ7) Peripheral clock period 60 to 302 us, high phase 30 to 151 us.
// (RQ8) Start-bit fall to parity-bit fall spans at most 2.002 ms.
// (RQ9) When sending, present each new bit within 1 us of a clock fall.
// (RQ10) Clear transmit select 3.5 to 7.1 us after rise following eleventh fall.
// (RQ11) Set transmit-idle within 500 ns of transmit select clearing; a disable during a send clears select but leaves transmit-idle low.
// (RQ12) Release data line when transmit select goes low.
// (RQ13) Transmit-idle rising raises an event kept until firmware writes one.
// (RQ14) When receiving, sample data line on each peripheral clock fall.
// (RQ15) Set receive-ready within 1.6 us of the eleventh received fall.
// (RQ16) Reading the receive register clears receive-ready within 500 ns.
// (RQ17) Hold clock line low after a frame until firmware reads the data.
// (RQ18) With the channel disabled, drive clock low and release data.
// (RQ19) Receive-ready rising raises an event.
// (RQ20) Frame: low start, eight bits LSB first, odd parity, high stop, acknowledge.
`timescale 1ns/10ps
module ps2_channel_controller #(
  parameter int START_DATA_CYCLES = ps2_pkg::START_DATA_CYC,
  parameter int CLK_FLOAT_CYCLES = ps2_pkg::CLK_FLOAT_CYC,
  parameter int END_TXSEL_CYCLES = ps2_pkg::END_TXSEL_CYC
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  // Register port
  input wire ps2_pkg::bus_req_t bus,
  output logic [7:0] rdata,
  // Clock line
  input wire logic port_clock_line_in,
  output logic port_clock_line_out,
  output logic port_clock_line_oe,
  // Data line
  input wire logic port_data_line_in,
  output logic port_data_line_out,
  output logic port_data_line_oe,
  // Events
  output logic [1:0] aggregated_irq_source_group
);
  import ps2_pkg::*;

  typedef enum {ST_OFF, ST_RX, ST_RX_HOLD, ST_TX_INHIBIT, ST_TX_START, ST_TX_BITS,
                ST_TX_END} state_t;

  logic clk_lvl, clk_fall, clk_rise;
  logic dat_lvl, dat_fall_unused, dat_rise_unused;

  ps2_sync u_clk_sync (
    .clk(clk),
    .rst(rst),
    .ce(ce),
    .async_in(port_clock_line_in),
    .level(clk_lvl),
    .fall(clk_fall),
    .rise(clk_rise)
  );

  ps2_sync u_dat_sync (
    .clk(clk),
    .rst(rst),
    .ce(ce),
    .async_in(port_data_line_in),
    .level(dat_lvl),
    .fall(dat_fall_unused),
    .rise(dat_rise_unused)
  );

  state_t state_reg, state_next;
  logic enable_reg, enable_next;
  logic txsel_reg, txsel_next;
  logic txidle_reg, txidle_next;
  logic rxrdy_reg, rxrdy_next;
  logic perr_reg, perr_next;
  logic [1:0] event_reg, event_next;
  logic [10:0] shift_reg, shift_next;
  logic [3:0] bitcnt_reg, bitcnt_next;
  logic [7:0] rxdata_reg, rxdata_next;
  logic [8:0] timer_reg, timer_next;
  logic [7:0] rdata_reg, rdata_next;
  logic clk_oe_reg, clk_oe_next;
  logic dat_oe_reg, dat_oe_next;
  logic started_reg, started_next;
  logic wr_tx, wr_ctrl, wr_stat, rd_rx;

  assign wr_tx = bus.wr && bus.addr == ADDR_TX;
  assign wr_ctrl = bus.wr && bus.addr == ADDR_CTRL;
  assign wr_stat = bus.wr && bus.addr == ADDR_STATUS;
  assign rd_rx = bus.rd && bus.addr == ADDR_RX;

  always_comb begin
    state_next = state_reg;
    enable_next = enable_reg;
    txsel_next = txsel_reg;
    txidle_next = txidle_reg;
    rxrdy_next = rxrdy_reg;
    perr_next = perr_reg;
    shift_next = shift_reg;
    bitcnt_next = bitcnt_reg;
    rxdata_next = rxdata_reg;
    timer_next = timer_reg;
    clk_oe_next = clk_oe_reg;
    dat_oe_next = dat_oe_reg;
    started_next = started_reg;
    event_next = event_reg;
    rdata_next = 8'h00;
    if (wr_ctrl) begin
      enable_next = bus.wdata[CTRL_ENABLE_POS];
      txsel_next = bus.wdata[CTRL_TXSEL_POS];
    end
    if (rd_rx) begin
      rxrdy_next = 1'b0; // RQ16
    end
    case (state_reg)
      ST_OFF: begin
        clk_oe_next = 1'b1; // RQ18
        dat_oe_next = 1'b0; // RQ18
        if (enable_next) begin
          state_next = txsel_next ? ST_TX_INHIBIT : ST_RX;
          bitcnt_next = 4'h0;
        end
      end
      ST_RX: begin
        clk_oe_next = 1'b0; // RQ1
        dat_oe_next = 1'b0; // RQ1
        if (clk_fall) begin
          shift_next = {dat_lvl, shift_reg[10:1]}; // RQ14
          bitcnt_next = bitcnt_reg + 4'h1;
          if (bitcnt_reg == 4'(FRAME_BITS - 1)) begin
            rxdata_next = shift_reg[9:2]; // RQ20
            perr_next = ~(^shift_reg[10:2]);
            rxrdy_next = 1'b1; // RQ15
            clk_oe_next = 1'b1; // RQ17
            state_next = ST_RX_HOLD;
          end
        end
      end
      ST_RX_HOLD: begin
        clk_oe_next = 1'b1; // RQ17
        bitcnt_next = 4'h0;
        if (rd_rx) begin
          clk_oe_next = 1'b0; // RQ17
          state_next = ST_RX;
        end
      end
      ST_TX_INHIBIT: begin
        clk_oe_next = 1'b1; // RQ2
        dat_oe_next = 1'b0;
        timer_next = 9'h000;
        started_next = 1'b0;
        if (wr_tx) begin
          shift_next = {1'b1, ~(^bus.wdata), bus.wdata, 1'b0}; // RQ20
          state_next = ST_TX_START;
        end
      end
      ST_TX_START: begin
        timer_next = timer_reg + 9'h001;
        if (timer_reg == 9'(START_DATA_CYCLES - 1)) begin
          dat_oe_next = 1'b1; // RQ4
        end
        if (timer_reg == 9'(CLK_FLOAT_CYCLES - 1)) begin
          clk_oe_next = 1'b0; // RQ5
          txidle_next = 1'b0; // RQ3
          bitcnt_next = 4'h0;
          shift_next = {1'b1, shift_reg[10:1]};
          state_next = ST_TX_BITS;
        end
      end
      ST_TX_BITS: begin
        // Peripheral may take up to 25 ms to clock; no timeout here, firmware owns that
        if (clk_fall) begin
          bitcnt_next = bitcnt_reg + 4'h1;
          if (bitcnt_reg < 4'(FRAME_BITS - 2)) begin
            dat_oe_next = ~shift_reg[0]; // RQ9
            shift_next = {1'b1, shift_reg[10:1]};
          end else begin
            dat_oe_next = 1'b0;
          end
        end
        if (clk_rise && bitcnt_reg == 4'(FRAME_BITS)) begin
          timer_next = 9'h000;
          state_next = ST_TX_END; // RQ20
        end
      end
      ST_TX_END: begin
        timer_next = timer_reg + 9'h001;
        if (timer_reg == 9'(END_TXSEL_CYCLES - 1)) begin
          txsel_next = 1'b0; // RQ10
          txidle_next = 1'b1; // RQ11
          dat_oe_next = 1'b0; // RQ12
          // Receive counts from zero; the send left eleven behind
          bitcnt_next = 4'h0;
          state_next = ST_RX;
        end
      end
      default: state_next = ST_OFF;
    endcase
    if (state_reg != ST_OFF && !enable_next) begin
      state_next = ST_OFF;
      clk_oe_next = 1'b1; // RQ18
      dat_oe_next = 1'b0; // RQ18
    end else if (state_reg != ST_OFF && state_next != ST_OFF && txsel_next
                 && (state_reg == ST_RX || state_reg == ST_RX_HOLD)) begin
      state_next = ST_TX_INHIBIT;
      clk_oe_next = 1'b1; // RQ2
      dat_oe_next = 1'b0;
    end else if (!txsel_next && state_reg >= ST_TX_INHIBIT && state_next != ST_RX) begin
      state_next = ST_RX;
      txidle_next = 1'b1;
      bitcnt_next = 4'h0;
      dat_oe_next = 1'b0; // RQ12
    end
    // Set wins over a write-one clear in the same cycle
    if (wr_stat) begin
      event_next = event_reg & ~{bus.wdata[STAT_EV_RXRDY_POS], bus.wdata[STAT_EV_TXIDLE_POS]};
    end
    if (txidle_next && !txidle_reg) begin
      event_next[0] = 1'b1; // RQ13
    end
    if (rxrdy_next && !rxrdy_reg) begin
      event_next[1] = 1'b1; // RQ19
    end
    if (bus.rd) begin
      case (bus.addr)
        ADDR_CTRL: rdata_next = {6'h00, txsel_reg, enable_reg};
        ADDR_STATUS: rdata_next = {2'h0, event_reg, 1'b0, perr_reg, rxrdy_reg, txidle_reg};
        ADDR_RX: rdata_next = rxdata_reg;
        default: rdata_next = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state_reg <= ST_OFF;
      enable_reg <= CTRL_RESET[CTRL_ENABLE_POS];
      txsel_reg <= CTRL_RESET[CTRL_TXSEL_POS];
      txidle_reg <= 1'b1;
      rxrdy_reg <= 1'b0;
      perr_reg <= 1'b0;
      event_reg <= 2'h0;
      shift_reg <= 11'h7ff;
      bitcnt_reg <= 4'h0;
      rxdata_reg <= 8'h00;
      timer_reg <= 9'h000;
      rdata_reg <= 8'h00;
      clk_oe_reg <= 1'b1;
      dat_oe_reg <= 1'b0;
      started_reg <= 1'b0;
    end else if (ce) begin
      state_reg <= state_next;
      enable_reg <= enable_next;
      txsel_reg <= txsel_next;
      txidle_reg <= txidle_next;
      rxrdy_reg <= rxrdy_next;
      perr_reg <= perr_next;
      event_reg <= event_next;
      shift_reg <= shift_next;
      bitcnt_reg <= bitcnt_next;
      rxdata_reg <= rxdata_next;
      timer_reg <= timer_next;
      rdata_reg <= rdata_next;
      clk_oe_reg <= clk_oe_next;
      dat_oe_reg <= dat_oe_next;
      started_reg <= started_next;
    end
  end

  assign rdata = rdata_reg;
  assign port_clock_line_oe = clk_oe_reg;
  assign port_clock_line_out = 1'b0;
  assign port_data_line_oe = dat_oe_reg;
  assign port_data_line_out = 1'b0;
  assign aggregated_irq_source_group = event_reg;
endmodule

/* File: verification/ps2_channel_monitor.sv */
/*
  Checker for the port channel controller, bound to its ports.
  Assumes the register bus of ps2_pkg and a tied-high clock enable.
*/
`timescale 1ns/10ps
module ps2_channel_monitor
  import ps2_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  // Register port
  input wire ps2_pkg::bus_req_t bus,
  input wire logic [7:0] rdata,
  // Lines
  input wire logic port_clock_line_in,
  input wire logic port_clock_line_out,
  input wire logic port_clock_line_oe,
  input wire logic port_data_line_in,
  input wire logic port_data_line_out,
  input wire logic port_data_line_oe,
  // Events
  input wire logic [1:0] aggregated_irq_source_group
);
  logic en_reg;
  wire ctl_wr = bus.wr && bus.addr == ADDR_CTRL;
  wire tx_go = bus.wr && bus.addr == ADDR_TX && en_reg && port_clock_line_oe && !port_data_line_oe;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // Shadow of the enable bit; hardware never clears it
  always_ff @(posedge clk) begin
    if (rst) begin
      en_reg <= 1'b0;
    end else if (ctl_wr) begin
      en_reg <= bus.wdata[CTRL_ENABLE_POS];
    end
  end
  chk_off_drive: assert property (!en_reg [*3] |-> port_clock_line_oe && !port_data_line_oe)
    else $error("disabled channel not holding clock low");
  chk_rx_float: assert property (ctl_wr && bus.wdata[1:0] == 2'b01 |->
    ##[1:20] !port_clock_line_oe && !port_data_line_oe) else $error("lines not released");
  chk_inhibit_clk: assert property (ctl_wr && bus.wdata[1:0] == 2'b11 |-> ##[1:3] port_clock_line_oe)
    else $error("clock not pulled for inhibit");
  chk_start_low: assert property (tx_go |-> ##[1:2] port_data_line_oe)
    else $error("start bit late");
  chk_clk_float: assert property (tx_go |-> ##[1:3] !port_clock_line_oe && port_data_line_oe)
    else $error("clock not released after send write");
  chk_hold_release: assert property (bus.rd && bus.addr == ADDR_RX && en_reg |-> ##[1:10] !port_clock_line_oe)
    else $error("clock hold not released by read");
  chk_idle_release: assert property ($rose(aggregated_irq_source_group[0]) |-> !port_data_line_oe)
    else $error("data still driven at idle");
  chk_event_hold: assert property (aggregated_irq_source_group[0] && !(bus.wr && bus.addr == ADDR_STATUS
    && bus.wdata[STAT_EV_TXIDLE_POS]) |=> aggregated_irq_source_group[0]) else $error("event lost");
  chk_rdata_quiet: assert property (!bus.rd |=> rdata == 8'h00)
    else $error("read data outside read slot");
endmodule

bind ps2_channel_controller ps2_channel_monitor i_ps2_channel_monitor (.clk(clk), .rst(rst),
  .ce(ce), .bus(bus), .rdata(rdata), .port_clock_line_in(port_clock_line_in),
  .port_clock_line_out(port_clock_line_out), .port_clock_line_oe(port_clock_line_oe),
  .port_data_line_in(port_data_line_in), .port_data_line_out(port_data_line_out),
  .port_data_line_oe(port_data_line_oe), .aggregated_irq_source_group(aggregated_irq_source_group));

/* File: verification/ps2_peripheral_model.sv */
/*
  Peripheral at the far end: sends frames on a 500 ns line clock, takes frames on a 400 ns one.
  Assumes open-drain wires with pull-ups, resolved by the bench.
*/
`timescale 1ns/10ps
module ps2_peripheral_model (
  // Resolved wires
  input wire logic clk_line,
  input wire logic data_line,
  // Send request
  input wire logic send_go,
  input wire logic bad_par,
  input wire logic [7:0] send_byte,
  // Pulls and results
  output logic clk_low,
  output logic data_low,
  output logic done,
  output logic ok,
  output logic [7:0] got
);
  logic [10:0] f;
  // Clock stands high outside frames
  task automatic tick();
    clk_low = 1'b1;
    #200;
    clk_low = 1'b0;
    #200;
  endtask
  initial begin
    clk_low = 0; data_low = 0; done = 1; ok = 0; got = 8'h00; f = '0;
    forever begin
      @(posedge send_go or negedge data_line);
      done = 1'b0;
      if (send_go) begin
        f = {1'b1, ~^send_byte ^ bad_par, send_byte, 1'b0};
        for (int i = 0; i < 11; i++) begin
          data_low = ~f[i];
          #100;
          tick();
        end
        data_low = 1'b0;
      end else begin
        wait (clk_line);
        #2000;
        for (int i = 0; i < 10; i++) begin
          clk_low = 1'b1;
          #200;
          clk_low = 1'b0;
          #100;
          f[i] = data_line;
          #100;
        end
        data_low = 1'b1;
        tick();
        data_low = 1'b0;
        got = f[7:0];
        ok = ^f[8:0] && f[9];
      end
      done = 1'b1;
    end
  end
endmodule

/* File: verification/ps2_channel_controller_tb.sv */
/*
  Self-checking bench: register tasks, peripheral model, table of frames.
  Assumes default parameters and a 20 MHz clock.
*/
`timescale 1ns/10ps
module ps2_channel_controller_tb;
  import ps2_pkg::*;
  typedef struct {bit dir; bit bad; logic [7:0] val; logic [7:0] st;} row_t;
  row_t rows [6] = '{'{1, 0, 8'hA5, 8'h11}, '{1, 0, 8'h00, 8'h11}, '{1, 0, 8'hFF, 8'h11},
    '{0, 0, 8'h3C, 8'h23}, '{0, 0, 8'h81, 8'h23}, '{0, 1, 8'h5A, 8'h27}};
  logic clk = 0, rst = 1, send_go = 0, bad_par = 0, clk_oe, dat_oe, m_clk, m_dat, m_done, m_ok;
  logic [7:0] send_byte = 8'h00, rdata, m_byte;
  logic [1:0] irq;
  bus_req_t bus = '0;
  int miscompares = 0, total_checks = 0, cycles = 0, n;
  wire clk_w = !(clk_oe | m_clk);
  wire dat_w = !(dat_oe | m_dat);
  wire [2:0] ev = {m_done, irq};
  ps2_channel_controller i_ps2_channel_controller (.clk(clk), .rst(rst), .ce(1'b1), .bus(bus),
    .rdata(rdata), .port_clock_line_in(clk_w), .port_clock_line_out(), .port_clock_line_oe(clk_oe),
    .port_data_line_in(dat_w), .port_data_line_out(), .port_data_line_oe(dat_oe),
    .aggregated_irq_source_group(irq));
  ps2_peripheral_model i_ps2_peripheral_model (.clk_line(clk_w), .data_line(dat_w),
    .send_go(send_go), .bad_par(bad_par), .send_byte(send_byte), .clk_low(m_clk),
    .data_low(m_dat), .done(m_done), .ok(m_ok), .got(m_byte));
  always #25 clk = ~clk;
  task automatic finish_test();
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk(logic [7:0] got, logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(logic [1:0] a, logic [7:0] d);
    @(posedge clk) bus <= '{a, d, 1'b1, 1'b0};
    @(posedge clk) bus.wr <= 1'b0;
  endtask
  task automatic rd(logic [1:0] a, logic [7:0] exp);
    @(posedge clk) bus <= '{a, 8'h00, 1'b0, 1'b1};
    @(posedge clk) bus.rd <= 1'b0;
    #1 chk(rdata, exp);
  endtask
  // Bounded wait; the count is also the measured latency
  task automatic wait_ev(int b);
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (ev[b] !== 1'b1 && n < 2000);
    if (n >= 2000) chk({5'h00, ev}, 8'hFF);
  endtask
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      finish_test();
    end
  end
  initial begin
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    rd(ADDR_CTRL, CTRL_RESET);
    rd(ADDR_STATUS, 8'h01);
    chk({6'h00, clk_w, dat_w}, 8'h01);
    wr(ADDR_CTRL, 8'h01);
    repeat (20) @(posedge clk);
    chk({6'h00, clk_w, dat_w}, 8'h03);
    $display("reset test done");
    foreach (rows[i]) begin
      if (rows[i].dir) begin
        wr(ADDR_CTRL, 8'h03);
        wr(ADDR_TX, rows[i].val);
        // Idle flag drops two edges after the write; read once it has
        @(posedge clk);
        rd(ADDR_STATUS, 8'h00);
        wait_ev(2);
        wait_ev(0);
        chk({7'h00, n >= 66 && n <= 148}, 8'h01);
        chk(m_byte, rows[i].val);
        chk({7'h00, m_ok}, 8'h01);
        rd(ADDR_CTRL, 8'h01);
        rd(ADDR_STATUS, rows[i].st);
      end else begin
        bad_par <= rows[i].bad;
        send_byte <= rows[i].val;
        send_go <= 1'b1;
        wait_ev(2);
        wait_ev(1);
        chk({7'h00, n <= 24}, 8'h01);
        send_go <= 1'b0;
        chk({7'h00, clk_oe}, 8'h01);
        rd(ADDR_STATUS, rows[i].st);
        rd(ADDR_RX, rows[i].val);
      end
      rd(ADDR_STATUS, rows[i].st & 8'hFD);
      wr(ADDR_STATUS, 8'h00);
      rd(ADDR_STATUS, rows[i].st & 8'hFD);
      wr(ADDR_STATUS, 8'h30);
      $display("row %0d done", i);
    end
    // Disable in mid-frame, then a second reset
    send_go <= 1'b1;
    repeat (40) @(posedge clk);
    wr(ADDR_CTRL, 8'h00);
    wait_ev(2);
    send_go <= 1'b0;
    chk({6'h00, clk_oe, dat_oe}, 8'h02);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    rd(ADDR_STATUS, 8'h01);
    $display("abort and reset test done");
    finish_test();
  end
endmodule
